/* File: rtl/sssrc_map.vh */
// register map, field positions, reset values and widths of the shadow register control block
// assumes inclusion by the block's design files and its testbench files
//
// Contract
// - keep front and working copies of zone, zone-enable and zoom settings
// - accept front-set writes at any time, even mid-frame
// - copy front to working at rising vblank only when control bit 1 set
// - after permit set, new settings apply from next rising vblank edge
// - with permit clear, working settings stay unchanged at vblank edges
// - permit only acts while engine enabled; disabled means no transfer
// - engine enable control that software sets to run, clears to stop
// - soft reset forces all measurement outputs to zero until cleared
// - on soft reset release, resync to frame timing before measuring
// - every register access carries a full 32-bit word by offset
// - one clock and one synchronous active-high reset for the block
// - host reaches registers over a slave port keeping its protocol; the block has a plain strobed port with i_wr and i_rd instead
`ifndef SSSRC_MAP_VH
`define SSSRC_MAP_VH

`define SSSRC_AW            6
`define SSSRC_DW            32

`define SSSRC_OFS_CONTROL   6'h00
`define SSSRC_OFS_STATUS    6'h04
`define SSSRC_OFS_HMAX0     6'h08
`define SSSRC_OFS_HMAX1     6'h0C
`define SSSRC_OFS_HMAX2     6'h10
`define SSSRC_OFS_VMAX0     6'h14
`define SSSRC_OFS_VMAX1     6'h18
`define SSSRC_OFS_VMAX2     6'h1C
`define SSSRC_OFS_RGB_EN    6'h20
`define SSSRC_OFS_YCC_EN    6'h24
`define SSSRC_OFS_ZOOM      6'h28
`define SSSRC_OFS_WORK_SEL  6'h2C

`define SSSRC_CTL_ENABLE    0
`define SSSRC_CTL_UPDATE    1
`define SSSRC_CTL_SRESET    2

`define SSSRC_ST_RUN        0
`define SSSRC_ST_SYNC       1
`define SSSRC_ST_XFER       2

`define SSSRC_BW            12
`define SSSRC_ZW            16
`define SSSRC_ZMW           2
`define SSSRC_NSET          8

`define SSSRC_RST_CONTROL   3'h0
`define SSSRC_RST_BOUND     12'h000
`define SSSRC_RST_ZONE      16'hFFFF
`define SSSRC_RST_ZOOM      2'h0

`endif

/* File: rtl/sssrc_edge.v */
// rising-edge detector for the vertical blanking pin
// assumes an asynchronous pin; two flip-flops before any logic reads it
`timescale 1ns/1ps
`default_nettype none
module sssrc_edge
(
	// clock and reset
	input  wire i_clk,
	input  wire i_rst,
	// pin and result
	input  wire i_pin,
	output reg  o_level,
	output reg  o_rise
);
	reg meta_q;
	reg sync_q;
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_q  <= 1'b0;
			sync_q  <= 1'b0;
			o_level <= 1'b0;
			o_rise  <= 1'b0;
		end
		else
		begin
			// only the second stage feeds logic
			meta_q  <= i_pin;
			sync_q  <= meta_q;
			o_level <= sync_q;
			o_rise  <= sync_q & ~o_level;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/sssrc_resync.v */
// soft-reset release sequencer: waits for a frame boundary before running
// assumes the vblank rise pulse is already synchronised to i_clk
`timescale 1ns/1ps
`default_nettype none
module sssrc_resync
(
	// clock and reset
	input  wire i_clk,
	input  wire i_rst,
	// control
	input  wire i_enable,
	input  wire i_sreset,
	input  wire i_vb_rise,
	// state
	output reg  o_run,
	output reg  o_syncing
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_RUN  = 2'h2;
	reg [1:0] state_q;
	reg [1:0] state_d;

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (i_enable && !i_sreset)
					state_d = ST_WAIT;
			ST_WAIT:
				if (i_sreset || !i_enable)
					state_d = ST_IDLE;
				else if (i_vb_rise)
					state_d = ST_RUN;
			ST_RUN:
				if (i_sreset || !i_enable)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_q   <= ST_IDLE;
			o_run     <= 1'b0;
			o_syncing <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			o_run     <= (state_d == ST_RUN);
			o_syncing <= (state_d == ST_WAIT);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/sssrc_top.v */
// shadow register control of a per-frame statistics engine
// assumes one clock, a synchronous active-high reset and an async vblank pin
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sssrc_map.vh"
module sssrc_top
(
	// clock and reset
	input  wire                     i_clk,
	input  wire                     i_rst,
	// register port
	input  wire [`SSSRC_AW-1:0]     i_addr,
	input  wire [`SSSRC_DW-1:0]     i_wdata,
	input  wire                     i_wr,
	input  wire                     i_rd,
	output reg  [`SSSRC_DW-1:0]     o_rdata,
	// video timing
	input  wire                     i_vblank,
	// working settings to the measurement logic
	output reg                      o_meas_run,
	output reg                      o_meas_clear,
	output reg  [`SSSRC_BW-1:0]     o_hmax0,
	output reg  [`SSSRC_BW-1:0]     o_hmax1,
	output reg  [`SSSRC_BW-1:0]     o_hmax2,
	output reg  [`SSSRC_BW-1:0]     o_vmax0,
	output reg  [`SSSRC_BW-1:0]     o_vmax1,
	output reg  [`SSSRC_BW-1:0]     o_vmax2,
	output reg  [`SSSRC_ZW-1:0]     o_rgb_zone_en,
	output reg  [`SSSRC_ZW-1:0]     o_ycc_zone_en,
	output reg  [`SSSRC_ZMW-1:0]    o_zoom
);
	// control bits: enable, update permit, soft reset
	reg [2:0]              ctl_q;
	// front set, written by software at any time
	reg [`SSSRC_BW-1:0]    fb_q [0:5];
	reg [`SSSRC_ZW-1:0]    frgb_q;
	reg [`SSSRC_ZW-1:0]    fycc_q;
	reg [`SSSRC_ZMW-1:0]   fzoom_q;
	// working set, drives measurement and is read back through the select register
	reg [`SSSRC_BW-1:0]    wb_q [0:5];
	reg [`SSSRC_ZW-1:0]    wrgb_q;
	reg [`SSSRC_ZW-1:0]    wycc_q;
	reg [`SSSRC_ZMW-1:0]   wzoom_q;
	reg                    xfer_seen_q;
	reg [2:0]              wsel_q;
	reg [`SSSRC_DW-1:0]    rdata_d;
	wire                   vb_rise;
	wire                   run;
	wire                   syncing;
	wire                   xfer;
	wire                   meas_force;
	integer                i;
	integer                j;

	// boundary index of an address, 7 when not a boundary register
	function [2:0] bnd_idx;
		input [`SSSRC_AW-1:0] a;
		begin
			case (a)
				`SSSRC_OFS_HMAX0:
				begin
					bnd_idx = 3'h0;
				end
				`SSSRC_OFS_HMAX1:
				begin
					bnd_idx = 3'h1;
				end
				`SSSRC_OFS_HMAX2:
				begin
					bnd_idx = 3'h2;
				end
				`SSSRC_OFS_VMAX0:
				begin
					bnd_idx = 3'h3;
				end
				`SSSRC_OFS_VMAX1:
				begin
					bnd_idx = 3'h4;
				end
				`SSSRC_OFS_VMAX2:
				begin
					bnd_idx = 3'h5;
				end
				default:
				begin
					bnd_idx = 3'h7;
				end
			endcase
		end
	endfunction

	// zero-extend a boundary to a bus word
	function [`SSSRC_DW-1:0] ext_b;
		input [`SSSRC_BW-1:0] v;
		begin
			ext_b = {{(`SSSRC_DW-`SSSRC_BW){1'b0}}, v};
		end
	endfunction

	// two-flop synchronised vblank, one-cycle rise pulse
	sssrc_edge u_vb
	(
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_pin   (i_vblank),
		.o_level (),
		.o_rise  (vb_rise)
	);

	// run state, waits for a frame edge after enable or soft reset release
	sssrc_resync u_sync
	(
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_enable  (ctl_q[`SSSRC_CTL_ENABLE]),
		.i_sreset  (ctl_q[`SSSRC_CTL_SRESET]),
		.i_vb_rise (vb_rise),
		.o_run     (run),
		.o_syncing (syncing)
	);

	// transfer only at rising vblank, with engine on and permit set
	assign xfer = vb_rise & ctl_q[`SSSRC_CTL_ENABLE]
		& ctl_q[`SSSRC_CTL_UPDATE];

	// disable and soft reset zero the outputs at once; run resumes at a frame edge
	assign meas_force = ~run | ctl_q[`SSSRC_CTL_SRESET] | ~ctl_q[`SSSRC_CTL_ENABLE];

	// front set and control writes, full word per access
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ctl_q   <= `SSSRC_RST_CONTROL;
			frgb_q  <= `SSSRC_RST_ZONE;
			fycc_q  <= `SSSRC_RST_ZONE;
			fzoom_q <= `SSSRC_RST_ZOOM;
			wsel_q  <= 3'h0;
			for (i = 0; i < 6; i = i + 1)
			begin
				fb_q[i] <= `SSSRC_RST_BOUND;
			end
		end
		else if (i_wr)
		begin
			if (bnd_idx(i_addr) != 3'h7)
				fb_q[bnd_idx(i_addr)] <= i_wdata[`SSSRC_BW-1:0];
			case (i_addr)
				`SSSRC_OFS_CONTROL:
				begin
					ctl_q <= i_wdata[2:0];
				end
				`SSSRC_OFS_RGB_EN:
				begin
					frgb_q <= i_wdata[`SSSRC_ZW-1:0];
				end
				`SSSRC_OFS_YCC_EN:
				begin
					fycc_q <= i_wdata[`SSSRC_ZW-1:0];
				end
				`SSSRC_OFS_ZOOM:
				begin
					fzoom_q <= i_wdata[`SSSRC_ZMW-1:0];
				end
				`SSSRC_OFS_WORK_SEL:
				begin
					wsel_q <= i_wdata[2:0];
				end
				default:
				begin
					wsel_q <= wsel_q;
				end
			endcase
		end
	end

	// working set, loaded from the front set on a permitted frame edge
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wrgb_q      <= `SSSRC_RST_ZONE;
			wycc_q      <= `SSSRC_RST_ZONE;
			wzoom_q     <= `SSSRC_RST_ZOOM;
			xfer_seen_q <= 1'b0;
			for (j = 0; j < 6; j = j + 1)
			begin
				wb_q[j] <= `SSSRC_RST_BOUND;
			end
		end
		else
		begin
			if (xfer)
			begin
				wrgb_q  <= frgb_q;
				wycc_q  <= fycc_q;
				wzoom_q <= fzoom_q;
				for (j = 0; j < 6; j = j + 1)
				begin
					wb_q[j] <= fb_q[j];
				end
			end
			// sticky, set wins over a read clear
			if (xfer)
				xfer_seen_q <= 1'b1;
			else if (i_rd && i_addr == `SSSRC_OFS_STATUS)
				xfer_seen_q <= 1'b0;
		end
	end

	// read mux; working set readable through the select register
	always @*
	begin
		rdata_d = {`SSSRC_DW{1'b0}};
		if (bnd_idx(i_addr) != 3'h7)
			rdata_d = ext_b(fb_q[bnd_idx(i_addr)]);
		case (i_addr)
			`SSSRC_OFS_CONTROL:
			begin
				rdata_d[2:0] = ctl_q;
			end
			`SSSRC_OFS_STATUS:
			begin
				rdata_d[2:0] = {xfer_seen_q, syncing, run};
			end
			`SSSRC_OFS_RGB_EN:
			begin
				rdata_d[`SSSRC_ZW-1:0] = frgb_q;
			end
			`SSSRC_OFS_YCC_EN:
			begin
				rdata_d[`SSSRC_ZW-1:0] = fycc_q;
			end
			`SSSRC_OFS_ZOOM:
			begin
				rdata_d[`SSSRC_ZMW-1:0] = fzoom_q;
			end
			`SSSRC_OFS_WORK_SEL:
			begin
				case (wsel_q)
					3'h6:
					begin
						rdata_d = {wycc_q, wrgb_q};
					end
					3'h7:
					begin
						rdata_d[`SSSRC_ZMW-1:0] = wzoom_q;
					end
					default:
					begin
						rdata_d = ext_b(wb_q[wsel_q]);
					end
				endcase
			end
			default:
			begin
				rdata_d = rdata_d;
			end
		endcase
	end

	// read data valid only the cycle after the strobe
	always @(posedge i_clk)
	begin
		if (i_rst)
			o_rdata <= {`SSSRC_DW{1'b0}};
		else if (i_rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= {`SSSRC_DW{1'b0}};
	end

	// measurement outputs, forced to zero with o_meas_clear high while not running
	always @(posedge i_clk)
	begin
		if (i_rst || meas_force)
		begin
			o_meas_run    <= 1'b0;
			o_meas_clear  <= 1'b1;
			o_hmax0       <= {`SSSRC_BW{1'b0}};
			o_hmax1       <= {`SSSRC_BW{1'b0}};
			o_hmax2       <= {`SSSRC_BW{1'b0}};
			o_vmax0       <= {`SSSRC_BW{1'b0}};
			o_vmax1       <= {`SSSRC_BW{1'b0}};
			o_vmax2       <= {`SSSRC_BW{1'b0}};
			o_rgb_zone_en <= {`SSSRC_ZW{1'b0}};
			o_ycc_zone_en <= {`SSSRC_ZW{1'b0}};
			o_zoom        <= {`SSSRC_ZMW{1'b0}};
		end
		else
		begin
			o_meas_run    <= 1'b1;
			o_meas_clear  <= 1'b0;
			o_hmax0       <= wb_q[0];
			o_hmax1       <= wb_q[1];
			o_hmax2       <= wb_q[2];
			o_vmax0       <= wb_q[3];
			o_vmax1       <= wb_q[4];
			o_vmax2       <= wb_q[5];
			o_rgb_zone_en <= wrgb_q;
			o_ycc_zone_en <= wycc_q;
			o_zoom        <= wzoom_q;
		end
	end
endmodule
`default_nettype wire

/* File: tb/sssrc_chk.sv */
// concurrent checks on the shadow register control top
// assumes binding onto sssrc_top, synchronous vblank stimulus
`timescale 1ns/1ps
`default_nettype none
`include "sssrc_map.vh"
module sssrc_chk
(
	// clock and reset
	input wire                  i_clk,
	input wire                  i_rst,
	// register port and video timing
	input wire [`SSSRC_AW-1:0]  i_addr,
	input wire [`SSSRC_DW-1:0]  i_wdata,
	input wire                  i_wr,
	input wire                  i_rd,
	input wire [`SSSRC_DW-1:0]  o_rdata,
	input wire                  i_vblank,
	// measurement side
	input wire                  o_meas_run,
	input wire                  o_meas_clear,
	input wire [`SSSRC_BW-1:0]  o_hmax0,
	input wire [`SSSRC_ZW-1:0]  o_ycc_zone_en,
	input wire [`SSSRC_ZMW-1:0] o_zoom
);
	reg       vb_q;
	reg [3:0] age_q;
	wire      ctl_wr = i_wr && (i_addr == `SSSRC_OFS_CONTROL);
	// cycles since the last vblank rise, saturating
	always @(posedge i_clk)
	begin
		vb_q <= i_vblank;
		if (i_rst)
			age_q <= 4'hF;
		else if (i_vblank && !vb_q)
			age_q <= 4'h0;
		else if (age_q != 4'hF)
			age_q <= age_q + 4'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 0)
		else $error("read data outside its slot");
	AST_CLR_ZERO: assert property (o_meas_clear |-> {o_hmax0, o_ycc_zone_en, o_zoom} == 0)
		else $error("outputs not zero while cleared");
	AST_EXCL: assert property (!(o_meas_run && o_meas_clear))
		else $error("run and clear together");
	AST_RST: assert property ($fell(i_rst) |-> o_meas_clear && !o_meas_run)
		else $error("reset state wrong");
	AST_SRST: assert property (ctl_wr && i_wdata[`SSSRC_CTL_SRESET] |-> ##2 o_meas_clear)
		else $error("soft reset did not clear");
	AST_DIS: assert property (ctl_wr && !i_wdata[`SSSRC_CTL_ENABLE] |-> ##2 o_meas_clear)
		else $error("disable did not stop");
	AST_WAKE: assert property ($rose(o_meas_run) |-> age_q < 4'h8)
		else $error("run started away from vblank");
	AST_HOLD: assert property (o_meas_run && $past(o_meas_run) && age_q > 4'h8
		|-> $stable(o_hmax0) && $stable(o_zoom))
		else $error("working set changed mid frame");
	cover property ($rose(o_meas_run));
	cover property ($rose(o_meas_clear));
	cover property (o_meas_run && $changed(o_hmax0));
endmodule
bind sssrc_top sssrc_chk i_sssrc_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_vblank, .o_meas_run, .o_meas_clear, .o_hmax0, .o_ycc_zone_en, .o_zoom);
`default_nettype wire

/* File: tb/sssrc_top_tb.sv */
// self-checking bench for the shadow register control top
// assumes a bound checker; stimulus launched on rising edges
`timescale 1ns/1ps
`default_nettype none
`include "sssrc_map.vh"
module sssrc_top_tb;
	reg                   i_clk, i_rst, i_wr, i_rd, i_vblank;
	reg  [`SSSRC_AW-1:0]  i_addr;
	reg  [`SSSRC_DW-1:0]  i_wdata;
	wire [`SSSRC_DW-1:0]  o_rdata;
	wire                  o_meas_run, o_meas_clear;
	wire [`SSSRC_BW-1:0]  o_hmax0, o_hmax1, o_hmax2, o_vmax0, o_vmax1, o_vmax2;
	wire [`SSSRC_ZW-1:0]  o_rgb_zone_en, o_ycc_zone_en;
	wire [`SSSRC_ZMW-1:0] o_zoom;
	integer               bad_count, num_checks, cyc;
	sssrc_top i_sssrc_top (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_vblank, .o_meas_run, .o_meas_clear, .o_hmax0, .o_hmax1, .o_hmax2, .o_vmax0,
		.o_vmax1, .o_vmax2, .o_rgb_zone_en, .o_ycc_zone_en, .o_zoom);
	task conclude;
	begin
		if (bad_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [`SSSRC_AW-1:0] a, input [31:0] d);
	begin
		@(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clk) i_wr <= 1'b0;
	end
	endtask
	task rd(input [`SSSRC_AW-1:0] a, input [31:0] e);
	begin
		@(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clk) i_rd <= 1'b0;
		@(negedge i_clk) cmp(o_rdata, e);
	end
	endtask
	task front(input [31:0] v);
	begin
		wr(`SSSRC_OFS_HMAX0, v);
		wr(`SSSRC_OFS_HMAX1, v + 32'h1);
		wr(`SSSRC_OFS_HMAX2, v + 32'h2);
		wr(`SSSRC_OFS_VMAX0, v + 32'h3);
		wr(`SSSRC_OFS_VMAX1, v + 32'h4);
		wr(`SSSRC_OFS_VMAX2, v + 32'h5);
		wr(`SSSRC_OFS_RGB_EN, v + 32'h6);
		wr(`SSSRC_OFS_YCC_EN, v + 32'h7);
		wr(`SSSRC_OFS_ZOOM, v);
	end
	endtask
	// v of zero means outputs held cleared, else the front set written by front(v)
	task outs(input [31:0] v);
		reg [31:0] k;
	begin
		k = (v == 32'h0) ? 32'h0 : 32'h1;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk) cmp({30'h0, o_meas_run, o_meas_clear}, {30'h0, k[0], ~k[0]});
		cmp({20'h0, o_hmax0}, v & 32'hFFF);
		cmp({20'h0, o_hmax1}, (v + k) & 32'hFFF);
		cmp({20'h0, o_hmax2}, (v + 32'h2 * k) & 32'hFFF);
		cmp({20'h0, o_vmax0}, (v + 32'h3 * k) & 32'hFFF);
		cmp({20'h0, o_vmax1}, (v + 32'h4 * k) & 32'hFFF);
		cmp({20'h0, o_vmax2}, (v + 32'h5 * k) & 32'hFFF);
		cmp({16'h0, o_rgb_zone_en}, (v + 32'h6 * k) & 32'hFFFF);
		cmp({16'h0, o_ycc_zone_en}, (v + 32'h7 * k) & 32'hFFFF);
		cmp({30'h0, o_zoom}, v & 32'h3);
	end
	endtask
	task vb;
	begin
		@(posedge i_clk) i_vblank <= 1'b1;
		repeat (8) @(posedge i_clk);
		i_vblank <= 1'b0;
		repeat (8) @(posedge i_clk);
	end
	endtask
	task t_regs;
	begin
		rd(`SSSRC_OFS_CONTROL, 32'h0);
		rd(`SSSRC_OFS_HMAX0, 32'h0);
		rd(`SSSRC_OFS_RGB_EN, 32'hFFFF);
		wr(6'h30, 32'h5);
		rd(6'h30, 32'h0);
		wr(`SSSRC_OFS_HMAX1, 32'hFFFFFABC);
		rd(`SSSRC_OFS_HMAX1, 32'hABC);
		outs(32'h0);
	end
	endtask
	task t_flow;
	begin
		front(32'h0123);
		wr(`SSSRC_OFS_CONTROL, 32'h3);
		outs(32'h0);
		vb;
		outs(32'h0123);
		wr(`SSSRC_OFS_CONTROL, 32'h1);
		front(32'h0456);
		vb;
		outs(32'h0123);
		rd(`SSSRC_OFS_HMAX0, 32'h456);
		wr(`SSSRC_OFS_CONTROL, 32'h3);
		vb;
		outs(32'h0456);
		front(32'h0789);
		vb;
		outs(32'h0789);
		rd(`SSSRC_OFS_STATUS, 32'h5);
		rd(`SSSRC_OFS_STATUS, 32'h1);
	end
	endtask
	task t_stop;
	begin
		wr(`SSSRC_OFS_CONTROL, 32'h2);
		front(32'h0ABC);
		vb;
		wr(`SSSRC_OFS_WORK_SEL, 32'h0);
		rd(`SSSRC_OFS_WORK_SEL, 32'h789);
		wr(`SSSRC_OFS_WORK_SEL, 32'h7);
		rd(`SSSRC_OFS_WORK_SEL, 32'h1);
		outs(32'h0);
		wr(`SSSRC_OFS_CONTROL, 32'h3);
		rd(`SSSRC_OFS_STATUS, 32'h2);
		vb;
		outs(32'h0ABC);
		wr(`SSSRC_OFS_CONTROL, 32'h7);
		outs(32'h0);
		vb;
		outs(32'h0);
		wr(`SSSRC_OFS_CONTROL, 32'h3);
		outs(32'h0);
		vb;
		outs(32'h0ABC);
		wr(`SSSRC_OFS_WORK_SEL, 32'h6);
		rd(`SSSRC_OFS_WORK_SEL, 32'h0AC30AC2);
	end
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 3000)
		begin
			bad_count = bad_count + 1;
			conclude;
		end
	end
	initial
	begin
		{i_rst, i_wr, i_rd, i_vblank, i_addr, i_wdata} = {1'b1, 3'b0, 6'h0, 32'h0};
		{bad_count, num_checks, cyc} = 0;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs;
		t_flow;
		t_stop;
		conclude;
	end
endmodule
`default_nettype wire
